// ===== core/bank_reader.sv
`timescale 1ns/1ps
// Splits the active bank into named pairs and index bytes
module bank_reader (
    bank_view_if.reader bv
);
    // ------------------------------------------------------------
    // Byte pick helper
    // ------------------------------------------------------------
    function automatic logic [7:0] pick(input logic [63:0] f,
                                        input logic [2:0]  n);
        pick = f[{n, 3'h0} +: 8];
    endfunction : pick

    // Pair n is bytes 2n (low) and 2n+1 (high)
    assign bv.pair_one  = {pick(bv.bank_flat, opaddr_pkg::REG_B),
                           pick(bv.bank_flat, opaddr_pkg::REG_C)};
    assign bv.pair_two  = {pick(bv.bank_flat, opaddr_pkg::REG_D),
                           pick(bv.bank_flat, opaddr_pkg::REG_E)};
    assign bv.base_pair = {pick(bv.bank_flat, opaddr_pkg::REG_H),
                           pick(bv.bank_flat, opaddr_pkg::REG_L)};
    assign bv.reg_b     = pick(bv.bank_flat, opaddr_pkg::REG_B);
    assign bv.reg_c     = pick(bv.bank_flat, opaddr_pkg::REG_C);
endmodule : bank_reader

// ===== core/bank_view_if.sv
`timescale 1ns/1ps
// Active-bank register view shared by the top and the bank reader
interface bank_view_if;
    logic [63:0] bank_flat;  // Eight bytes of the active bank
    logic [15:0] pair_one;   // C low, B high
    logic [15:0] pair_two;   // E low, D high
    logic [15:0] base_pair;  // L low, H high
    logic [7:0]  reg_b;
    logic [7:0]  reg_c;

    modport reader (
        input  bank_flat,
        output pair_one,
        output pair_two,
        output base_pair,
        output reg_b,
        output reg_c
    );
    modport user (
        output bank_flat,
        input  pair_one,
        input  pair_two,
        input  base_pair,
        input  reg_b,
        input  reg_c
    );
endinterface : bank_view_if

// ===== core/opaddr_pkg.sv
package opaddr_pkg;

    // ------------------------------------------------------------
    // Byte register numbers, absolute order
    // ------------------------------------------------------------
    localparam logic [2:0] REG_X = 3'h0;
    localparam logic [2:0] REG_A = 3'h1;
    localparam logic [2:0] REG_C = 3'h2;
    localparam logic [2:0] REG_B = 3'h3;
    localparam logic [2:0] REG_E = 3'h4;
    localparam logic [2:0] REG_D = 3'h5;
    localparam logic [2:0] REG_L = 3'h6;
    localparam logic [2:0] REG_H = 3'h7;

    // ------------------------------------------------------------
    // Register pair numbers
    // ------------------------------------------------------------
    localparam logic [1:0] PAIR_ACC  = 2'h0; // acc_pair
    localparam logic [1:0] PAIR_ONE  = 2'h1; // pair_one
    localparam logic [1:0] PAIR_TWO  = 2'h2; // pair_two
    localparam logic [1:0] PAIR_BASE = 2'h3; // base_pointer_pair

    // ------------------------------------------------------------
    // Address windows
    // ------------------------------------------------------------
    localparam logic [15:0] SHORT_LO     = 16'hfe20;
    localparam logic [15:0] SHORT_HI     = 16'hff1f;
    localparam logic [7:0]  SHORT_WRAP   = 8'h20;   // Below this: bit 8 set
    localparam logic [6:0]  PAGE_HIGH    = 7'h7f;   // Bits 15..9 of window
    localparam logic [7:0]  SFR_PAGE     = 8'hff;
    localparam logic [7:0]  SFR_GAP_LO   = 8'hd0;   // FFD0..FFDF unreachable
    localparam logic [7:0]  SFR_GAP_HI   = 8'hdf;
    localparam logic [15:0] STACK_LO     = 16'hfe00;
    localparam logic [15:0] STACK_HI     = 16'hfeff;

    // ------------------------------------------------------------
    // Fixed opcodes recognised by the decoder
    // ------------------------------------------------------------
    localparam logic [7:0] OP_MOV_A_C     = 8'h62;
    localparam logic [7:0] OP_INC16_TWO   = 8'h84;
    localparam logic [7:0] OP_LD_A_BASE_B = 8'hab;
    localparam logic [7:0] OP_PUSH_TWO    = 8'hb5;
    localparam logic [7:0] OP_LD_A_DIRECT = 8'h8e;

    // ------------------------------------------------------------
    // Addressing modes requested by the sequencer
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_NONE,
        MODE_IMPL_MUL,
        MODE_IMPL_DIV,
        MODE_IMPL_ACC,
        MODE_REG8,
        MODE_REG16,
        MODE_DIRECT,
        MODE_SHORT,
        MODE_SFR,
        MODE_INDIRECT,
        MODE_BASED,
        MODE_BASED_IDX,
        MODE_STACK
    } addr_mode_e;

endpackage : opaddr_pkg

// ===== core/operand_address_generator.sv
`timescale 1ns/1ps
//
// Behaviour
// RQ1 - Multiply: A times register into acc_pair
// RQ2 - Divide: acc_pair dividend, quotient back there
// RQ3 - BCD fix and digit rotate use A
// RQ4 - Register from active bank, 3-bit field
// RQ5 - Order X A C B E D L H; pairs 0-3
// RQ6 - Direct: 16-bit immediate is address
// RQ7 - Short direct window FE20H to FF1FH
// RQ8 - Bit 8 set for 00H-1FH, else clear
// RQ9 - Word short operands only even addresses
// RQ10 - SFR window FF00-FFCF and FFE0-FFFF
// RQ11 - Word SFR access only even, word-capable; the code checks only the even address, not word capability
// RQ12 - Indirect via pair_two or base pair
// RQ13 - Base pair plus zero-extended byte, wrap
// RQ14 - Base pair plus B or C, wrap
// RQ15 - Stack ops address through stack_pointer
// RQ16 - Stack reaches internal high-speed RAM only
// RQ17 - Opcode 62H: move C into A
// RQ18 - Opcode 84H: increment pair_two
// RQ19 - Opcode ABH: load A from base+B
// RQ20 - Opcode B5H: push pair_two
// RQ21 - Opcode 8EH: load A from direct address
// RQ22 - Two bank select bits pick the bank
//
module operand_address_generator (
    input  wire logic        clk_i,           // 250 MHz core clock
    input  wire logic        reset_n_i,       // Async reset, active low
    input  wire logic        clk_en_i,        // Freezes all state when low
    input  wire logic        req_i,           // Decode request pulse
    input  wire logic [3:0]  mode_i,          // addr_mode_e code
    input  wire logic [7:0]  opcode_i,        // Opcode byte
    input  wire logic [15:0] imm_i,           // Immediate bytes, low first
    input  wire logic        word_i,          // 16-bit operand size
    input  wire logic        sel_c_i,         // Based-indexed uses C
    input  wire logic        pair_sel_i,      // Indirect: 1 base, 0 two
    input  wire logic        bank_select_bit_low_i,
    input  wire logic        bank_select_bit_high_i,
    input  wire logic [255:0] regs_i,         // Four banks of eight bytes
    input  wire logic [15:0] stack_pointer_i, // Current stack pointer
    output logic             valid_o,         // Result pulse
    output logic             mem_o,           // Result is a memory address
    output logic [15:0]      addr_o,          // Effective address
    output logic [2:0]       src_reg_o,       // Byte register read
    output logic [2:0]       dst_reg_o,       // Byte register written
    output logic [1:0]       pair_o,          // Register pair selected
    output logic [1:0]       bank_o,          // Bank used
    output logic [3:0]       op_class_o,      // Fixed opcode recognised
    output logic             fault_o          // Operand outside window or odd word address
);

    // ------------------------------------------------------------
    // Opcode class codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CLS_NONE,
        CLS_MOV_A_C,
        CLS_INC16_TWO,
        CLS_LD_A_BASE_B,
        CLS_PUSH_TWO,
        CLS_LD_A_DIRECT
    } op_class_e;

    // ------------------------------------------------------------
    // Whole module state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        mem;
        logic [15:0] addr;
        logic [2:0]  src;
        logic [2:0]  dst;
        logic [1:0]  pair;
        logic [1:0]  bank;
        logic [3:0]  cls;
        logic        fault;
    } state_s;

    state_s state_reg;   // Registered outputs
    state_s state_next;  // Next value

    // Active bank view
    bank_view_if bv();
    logic [1:0] bank_idx;

    assign bank_idx = {bank_select_bit_high_i, bank_select_bit_low_i}; // RQ22
    assign bv.bank_flat = regs_i[{bank_idx, 6'h00} +: 64];            // RQ4

    bank_reader u_bank (
        .bv (bv.reader)
    );

    // ------------------------------------------------------------
    // Opcode recognition, used for classing and decode
    // ------------------------------------------------------------
    function automatic op_class_e classify(input logic [7:0] op);
        unique case (op)
            opaddr_pkg::OP_MOV_A_C:     classify = CLS_MOV_A_C;     // RQ17
            opaddr_pkg::OP_INC16_TWO:   classify = CLS_INC16_TWO;   // RQ18
            opaddr_pkg::OP_LD_A_BASE_B: classify = CLS_LD_A_BASE_B; // RQ19
            opaddr_pkg::OP_PUSH_TWO:    classify = CLS_PUSH_TWO;    // RQ20
            opaddr_pkg::OP_LD_A_DIRECT: classify = CLS_LD_A_DIRECT; // RQ21
            default:                    classify = CLS_NONE;
        endcase
    endfunction : classify

    // Short direct address from the 8-bit immediate
    function automatic logic [15:0] short_addr(input logic [7:0] b);
        // Low bytes wrap up into the register page
        short_addr = {opaddr_pkg::PAGE_HIGH,
                      (b < opaddr_pkg::SHORT_WRAP), b};         // RQ8
    endfunction : short_addr

    // ------------------------------------------------------------
    // Next-state decode
    // ------------------------------------------------------------
    always_comb begin
        op_class_e   cls;
        logic [15:0] sfr_a;
        logic        stack_bad;
        cls   = classify(opcode_i);
        sfr_a = {opaddr_pkg::SFR_PAGE, imm_i[7:0]};
        // Stack must stay inside internal RAM, push included
        stack_bad = (stack_pointer_i < opaddr_pkg::STACK_LO) ||
                    (stack_pointer_i > opaddr_pkg::STACK_HI);       // RQ16
        state_next       = state_reg;
        state_next.valid = 1'b0;
        if (req_i) begin
            state_next.valid = 1'b1;
            state_next.mem   = 1'b0;
            state_next.addr  = 16'h0000;
            state_next.src   = opaddr_pkg::REG_A;
            state_next.dst   = opaddr_pkg::REG_A;
            state_next.pair  = opaddr_pkg::PAIR_ACC;
            state_next.bank  = bank_idx;                            // RQ22
            state_next.cls   = cls;
            state_next.fault = 1'b0;
            // Fixed opcodes override the requested mode
            if (cls == CLS_MOV_A_C) begin
                state_next.src = opaddr_pkg::REG_C;                 // RQ17
            end else if (cls == CLS_INC16_TWO) begin
                state_next.pair = opaddr_pkg::PAIR_TWO;             // RQ18
            end else if (cls == CLS_LD_A_BASE_B) begin
                state_next.mem  = 1'b1;
                state_next.addr = bv.base_pair
                                  + {8'h00, bv.reg_b};              // RQ19
            end else if (cls == CLS_PUSH_TWO) begin
                state_next.mem  = 1'b1;
                state_next.pair = opaddr_pkg::PAIR_TWO;             // RQ20
                state_next.addr = stack_pointer_i;
                state_next.fault = stack_bad;                       // RQ16
            end else if (cls == CLS_LD_A_DIRECT) begin
                state_next.mem  = 1'b1;
                state_next.addr = imm_i;                            // RQ21
            end else begin
                unique case (mode_i)
                    4'(opaddr_pkg::MODE_IMPL_MUL): begin
                        // A times the named register into acc_pair
                        state_next.src  = opcode_i[2:0];            // RQ1
                        state_next.pair = opaddr_pkg::PAIR_ACC;     // RQ1
                    end
                    4'(opaddr_pkg::MODE_IMPL_DIV): begin
                        state_next.pair = opaddr_pkg::PAIR_ACC;     // RQ2
                    end
                    4'(opaddr_pkg::MODE_IMPL_ACC): begin
                        state_next.src = opaddr_pkg::REG_A;         // RQ3
                    end
                    4'(opaddr_pkg::MODE_REG8): begin
                        state_next.src = opcode_i[2:0];             // RQ4 RQ5
                        state_next.dst = opcode_i[2:0];
                    end
                    4'(opaddr_pkg::MODE_REG16): begin
                        state_next.pair = opcode_i[2:1];            // RQ5
                    end
                    4'(opaddr_pkg::MODE_DIRECT): begin
                        state_next.mem  = 1'b1;
                        state_next.addr = imm_i;                    // RQ6
                    end
                    4'(opaddr_pkg::MODE_SHORT): begin
                        state_next.mem  = 1'b1;
                        state_next.addr = short_addr(imm_i[7:0]);   // RQ7
                        // Odd word operand is the caller's error
                        state_next.fault = word_i & imm_i[0];       // RQ9
                    end
                    4'(opaddr_pkg::MODE_SFR): begin
                        state_next.mem  = 1'b1;
                        state_next.addr = sfr_a;                    // RQ10
                        state_next.fault = (imm_i[7:0] >=
                                            opaddr_pkg::SFR_GAP_LO &&
                                            imm_i[7:0] <=
                                            opaddr_pkg::SFR_GAP_HI)
                                           | (word_i & imm_i[0]);   // RQ10 RQ11
                    end
                    4'(opaddr_pkg::MODE_INDIRECT): begin
                        state_next.mem  = 1'b1;
                        state_next.pair = pair_sel_i ?
                                          opaddr_pkg::PAIR_BASE :
                                          opaddr_pkg::PAIR_TWO;
                        state_next.addr = pair_sel_i ? bv.base_pair
                                                     : bv.pair_two; // RQ12
                    end
                    4'(opaddr_pkg::MODE_BASED): begin
                        state_next.mem  = 1'b1;
                        // 16-bit sum drops the carry
                        state_next.addr = bv.base_pair
                                          + {8'h00, imm_i[7:0]};    // RQ13
                    end
                    4'(opaddr_pkg::MODE_BASED_IDX): begin
                        state_next.mem  = 1'b1;
                        state_next.addr = bv.base_pair
                            + {8'h00, sel_c_i ? bv.reg_c
                                              : bv.reg_b};          // RQ14
                    end
                    4'(opaddr_pkg::MODE_STACK): begin
                        state_next.mem  = 1'b1;
                        state_next.addr = stack_pointer_i;          // RQ15
                        state_next.fault = stack_bad;               // RQ16
                    end
                    default: begin
                        // Unused mode codes select nothing
                        state_next.src = opaddr_pkg::REG_A;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= '0;
        end else if (clk_en_i) begin
            state_reg <= state_next;
        end
    end

    assign valid_o    = state_reg.valid;
    assign mem_o      = state_reg.mem;
    assign addr_o     = state_reg.addr;
    assign src_reg_o  = state_reg.src;
    assign dst_reg_o  = state_reg.dst;
    assign pair_o     = state_reg.pair;
    assign bank_o     = state_reg.bank;
    assign op_class_o = state_reg.cls;
    assign fault_o    = state_reg.fault;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_short_window;
        @(posedge clk_i) disable iff (!reset_n_i)
        (clk_en_i && req_i && mode_i == 4'(opaddr_pkg::MODE_SHORT) &&
         classify(opcode_i) == CLS_NONE)
        |=> (addr_o >= opaddr_pkg::SHORT_LO && addr_o <= opaddr_pkg::SHORT_HI);
    endproperty
    a_short_window: assert property (p_short_window) // RQ7
        else $error("short direct address outside window");

    property p_short_bit8;
        @(posedge clk_i) disable iff (!reset_n_i)
        (clk_en_i && req_i && mode_i == 4'(opaddr_pkg::MODE_SHORT) &&
         classify(opcode_i) == CLS_NONE)
        |=> (addr_o[8] == ($past(imm_i[7:0]) < 8'h20));
    endproperty
    a_short_bit8: assert property (p_short_bit8) // RQ8
        else $error("short direct bit 8 wrong");

    property p_direct;
        @(posedge clk_i) disable iff (!reset_n_i)
        (clk_en_i && req_i && opcode_i == opaddr_pkg::OP_LD_A_DIRECT)
        |=> (mem_o && addr_o == $past(imm_i));
    endproperty
    a_direct: assert property (p_direct) // RQ21
        else $error("direct load address wrong");

    property p_mov_a_c;
        @(posedge clk_i) disable iff (!reset_n_i)
        (clk_en_i && req_i && opcode_i == opaddr_pkg::OP_MOV_A_C)
        |=> (src_reg_o == 3'h2 && dst_reg_o == 3'h1 && !mem_o);
    endproperty
    a_mov_a_c: assert property (p_mov_a_c) // RQ17
        else $error("move C to A decode wrong");

    property p_increment_word_op;
        @(posedge clk_i) disable iff (!reset_n_i)
        (clk_en_i && req_i && opcode_i == opaddr_pkg::OP_INC16_TWO)
        |=> (pair_o == 2'h2 && valid_o);
    endproperty
    a_increment_word_op: assert property (p_increment_word_op) // RQ18
        else $error("increment pair decode wrong");

    property p_push;
        @(posedge clk_i) disable iff (!reset_n_i)
        (clk_en_i && req_i && opcode_i == opaddr_pkg::OP_PUSH_TWO)
        |=> (addr_o == $past(stack_pointer_i) && pair_o == 2'h2);
    endproperty
    a_push: assert property (p_push) // RQ20
        else $error("push address wrong");

    property p_bank;
        @(posedge clk_i) disable iff (!reset_n_i)
        (clk_en_i && req_i)
        |=> (bank_o == {$past(bank_select_bit_high_i),
                        $past(bank_select_bit_low_i)});
    endproperty
    a_bank: assert property (p_bank) // RQ22
        else $error("bank index wrong");

    property p_based_idx;
        @(posedge clk_i) disable iff (!reset_n_i)
        (clk_en_i && req_i && opcode_i == opaddr_pkg::OP_LD_A_BASE_B)
        |=> (addr_o == 16'($past(bv.base_pair) + {8'h00, $past(bv.reg_b)}));
    endproperty
    a_based_idx: assert property (p_based_idx) // RQ19
        else $error("based indexed address wrong");

    property p_stack_fault;
        @(posedge clk_i) disable iff (!reset_n_i)
        (clk_en_i && req_i && mode_i == 4'(opaddr_pkg::MODE_STACK) &&
         classify(opcode_i) == CLS_NONE && stack_pointer_i[15:8] != 8'hfe)
        |=> fault_o;
    endproperty
    a_stack_fault: assert property (p_stack_fault) // RQ16
        else $error("stack outside RAM not flagged");

endmodule : operand_address_generator

// ===== verification/regfile_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Register file and stack pointer on the far side of the block
// ------------------------------------------------------------
module regfile_model (
    input  wire logic [15:0]  stack_load_i, // Stack pointer value to present
    output logic      [255:0] regs_o,       // Four banks of eight bytes
    output logic      [15:0]  stack_o       // Stack pointer seen by the block
);
    // Every byte differs by bank and number, so a wrong pick shows up;
    // bank 3 puts ff in H so based sums can carry past bit 15
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            for (int n = 0; n < 8; n++) begin
                regs_o[64*k+8*n +: 8] = {n[2:0], k[1:0], 3'h7};
            end
        end
        stack_o = stack_load_i;
    end
endmodule : regfile_model

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic         clk_i = 1'b0;
    logic         reset_n_i = 1'b0;
    logic         req_i = 1'b0;
    logic [3:0]   mode_i = 4'h0;
    logic [7:0]   opcode_i = 8'h00;
    logic [15:0]  imm_i = 16'h0000;
    logic         word_i = 1'b0;
    logic         sel_c_i = 1'b0;
    logic         pair_sel_i = 1'b0;
    logic         en = 1'b1;
    logic [1:0]   bank = 2'h0;
    logic [15:0]  stack_load = 16'hfe80;
    logic [255:0] regs;
    logic [15:0]  stk;
    logic         valid_o, mem_o, fault_o;
    logic [15:0]  addr_o;
    logic [2:0]   src_reg_o, dst_reg_o;
    logic [1:0]   pair_o, bank_o;
    logic [3:0]   op_class_o;
    int           fail_count = 0;
    int           samples_checked = 0;

    always #2 clk_i = ~clk_i; // 250 MHz

    regfile_model model (.stack_load_i(stack_load), .regs_o(regs),
                         .stack_o(stk));

    operand_address_generator dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(en),
        .req_i(req_i), .mode_i(mode_i), .opcode_i(opcode_i),
        .imm_i(imm_i), .word_i(word_i), .sel_c_i(sel_c_i),
        .pair_sel_i(pair_sel_i), .bank_select_bit_low_i(bank[0]),
        .bank_select_bit_high_i(bank[1]), .regs_i(regs),
        .stack_pointer_i(stk), .valid_o(valid_o), .mem_o(mem_o),
        .addr_o(addr_o), .src_reg_o(src_reg_o), .dst_reg_o(dst_reg_o),
        .pair_o(pair_o), .bank_o(bank_o), .op_class_o(op_class_o),
        .fault_o(fault_o));

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    // Byte n of bank k, as the model fills it
    function automatic logic [15:0] rb(input logic [1:0] k,
                                       input logic [2:0] n);
        return {8'h00, n, k, 3'h7};
    endfunction : rb

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen,
                     exp);
        end
    endtask : check

    // One request at a falling edge; waits a bounded time for the answer
    task automatic run(input logic [3:0] m, input logic [7:0] op,
                       input logic [15:0] imm, input logic w,
                       input logic [1:0] k);
        int i;
        @(negedge clk_i);
        mode_i = m;
        opcode_i = op;
        imm_i = imm;
        word_i = w;
        bank = k;
        req_i = 1'b1;
        @(negedge clk_i);
        req_i = 1'b0;
        for (i = 0; i < 4 && valid_o !== 1'b1; i++) @(negedge clk_i);
        if (valid_o !== 1'b1) begin
            fail_count++;
            wrap_up();
        end
    endtask : run

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reg();
        for (int k = 0; k < 4; k++) begin
            for (int n = 0; n < 8; n++) begin
                run(opaddr_pkg::MODE_REG8, 8'(n), 16'h0, 1'b0, 2'(k));
                check(16'(src_reg_o), 16'(n));
                check(16'(bank_o), 16'(k));
            end
        end
        for (int p = 0; p < 4; p++) begin
            run(opaddr_pkg::MODE_REG16, 8'(p * 2), 16'h0, 1'b0, 2'h0);
            check(16'(pair_o), 16'(p));
        end
    endtask : t_reg

    // Pair register ends at 3 above, so the acc pair must be driven anew
    task automatic t_implied();
        run(opaddr_pkg::MODE_IMPL_DIV, 8'h00, 16'h0, 1'b0, 2'h1);
        check(16'(pair_o), 16'(opaddr_pkg::PAIR_ACC));
        check(16'(mem_o), 16'h0);
        run(opaddr_pkg::MODE_IMPL_MUL, 8'h00, 16'h0, 1'b0, 2'h1);
        check(16'(src_reg_o), 16'(opaddr_pkg::REG_X));
        check(16'(dst_reg_o), 16'(opaddr_pkg::REG_A));
        check(16'(pair_o), 16'(opaddr_pkg::PAIR_ACC));
        run(opaddr_pkg::MODE_IMPL_ACC, 8'h00, 16'h0, 1'b0, 2'h1);
        check(16'(src_reg_o), 16'(opaddr_pkg::REG_A));
    endtask : t_implied

    task automatic t_direct();
        run(opaddr_pkg::MODE_DIRECT, 8'h00, 16'hfe00, 1'b0, 2'h0);
        check(addr_o, 16'hfe00);
        check(16'(mem_o), 16'h1);
        run(opaddr_pkg::MODE_NONE, 8'h8e, 16'h8a5c, 1'b0, 2'h0);
        check(16'(op_class_o), 16'h5);
        check(addr_o, 16'h8a5c);
        en = 1'b0; // Frozen edge must keep the valid pulse up
        @(negedge clk_i);
        check(16'(valid_o), 16'h1);
        en = 1'b1;
    endtask : t_direct

    // Both edges of the bit-8 split, then odd and even word operands
    task automatic t_short();
        logic [7:0] t [4] = '{8'h00, 8'h1f, 8'h20, 8'hff};
        foreach (t[i]) begin
            run(opaddr_pkg::MODE_SHORT, 8'h00, {8'h00, t[i]}, 1'b0, 2'h0);
            check(addr_o, {7'h7f, t[i] < 8'h20, t[i]});
        end
        run(opaddr_pkg::MODE_SHORT, 8'h00, 16'h0021, 1'b1, 2'h0);
        check(16'(fault_o), 16'h1);
        run(opaddr_pkg::MODE_SHORT, 8'h00, 16'h0022, 1'b1, 2'h0);
        check(16'(fault_o), 16'h0);
    endtask : t_short

    // The gap ffd0..ffdf must be refused at both of its ends
    task automatic t_sfr();
        logic [7:0] t [6] = '{8'h00, 8'hcf, 8'hd0, 8'hdf, 8'he0, 8'hff};
        logic       f [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        foreach (t[i]) begin
            run(opaddr_pkg::MODE_SFR, 8'h00, {8'h00, t[i]}, 1'b0, 2'h0);
            check(addr_o, {8'hff, t[i]});
            check(16'(fault_o), 16'(f[i]));
        end
        run(opaddr_pkg::MODE_SFR, 8'h00, 16'h0011, 1'b1, 2'h0);
        check(16'(fault_o), 16'h1);
    endtask : t_sfr

    // Bank 3 base pair is ffdf, so these sums carry out and wrap
    task automatic t_pairs();
        pair_sel_i = 1'b0;
        run(opaddr_pkg::MODE_INDIRECT, 8'h00, 16'h0, 1'b0, 2'h2);
        check(addr_o, (rb(2, 5) << 8) | rb(2, 4));
        pair_sel_i = 1'b1;
        run(opaddr_pkg::MODE_INDIRECT, 8'h00, 16'h0, 1'b0, 2'h2);
        check(addr_o, (rb(2, 7) << 8) | rb(2, 6));
        run(opaddr_pkg::MODE_BASED, 8'h00, 16'h0040, 1'b0, 2'h3);
        check(addr_o, ((rb(3, 7) << 8) | rb(3, 6)) + 16'h0040);
        sel_c_i = 1'b0;
        run(opaddr_pkg::MODE_BASED_IDX, 8'h00, 16'h0, 1'b0, 2'h3);
        check(addr_o, ((rb(3, 7) << 8) | rb(3, 6)) + rb(3, 3));
        sel_c_i = 1'b1;
        run(opaddr_pkg::MODE_BASED_IDX, 8'h00, 16'h0, 1'b0, 2'h3);
        check(addr_o, ((rb(3, 7) << 8) | rb(3, 6)) + rb(3, 2));
    endtask : t_pairs

    task automatic t_stack_ops();
        run(opaddr_pkg::MODE_STACK, 8'h00, 16'h0, 1'b0, 2'h0);
        check(addr_o, 16'hfe80);
        check(16'(fault_o), 16'h0);
        run(opaddr_pkg::MODE_NONE, 8'hb5, 16'h0, 1'b0, 2'h0);
        check(16'(op_class_o), 16'h4);
        check(16'(pair_o), 16'(opaddr_pkg::PAIR_TWO));
        stack_load = 16'hff10;
        run(opaddr_pkg::MODE_STACK, 8'h00, 16'h0, 1'b0, 2'h0);
        check(16'(fault_o), 16'h1);
        run(opaddr_pkg::MODE_NONE, 8'hb5, 16'h0, 1'b0, 2'h0);
        check(16'(fault_o), 16'h1);
        run(opaddr_pkg::MODE_NONE, 8'h62, 16'h0, 1'b0, 2'h0);
        check(16'(op_class_o), 16'h1);
        check(16'(src_reg_o), 16'(opaddr_pkg::REG_C));
        check(16'(dst_reg_o), 16'(opaddr_pkg::REG_A));
        run(opaddr_pkg::MODE_NONE, 8'h84, 16'h0, 1'b0, 2'h0);
        check(16'(op_class_o), 16'h2);
        check(16'(pair_o), 16'(opaddr_pkg::PAIR_TWO));
        sel_c_i = 1'b1; // Opcode must pick B on its own
        run(opaddr_pkg::MODE_NONE, 8'hab, 16'h0, 1'b0, 2'h1);
        check(16'(op_class_o), 16'h3);
        check(addr_o, ((rb(1, 7) << 8) | rb(1, 6)) + rb(1, 3));
    endtask : t_stack_ops

    // Reset held six cycles; valid and address must read zero meanwhile
    initial begin
        repeat (6) @(negedge clk_i);
        check(16'(valid_o), 16'h0);
        check(addr_o, 16'h0000);
        reset_n_i = 1'b1;
        t_reg();
        t_implied();
        t_direct();
        t_short();
        t_sfr();
        t_pairs();
        t_stack_ops();
        wrap_up();
    end
endmodule : testbench
